//--- test/bcts_file_model.sv
// Purpose: File register model
// Assumes: Read data held after a read
// Notes:   Behavioural
`timescale 1ns/100ps
module bcts_file_model
(
    input  wire logic               ref_clk,
    input  bcts_pkg::bcts_file_req_t req,
    output logic [7:0]              rdata
);
    logic [7:0] mem [128];
    always @(posedge ref_clk)
    begin
        if (req.rd_en) rdata <= mem[req.addr];
        if (req.wr_en) mem[req.addr] <= req.wdata;
    end
endmodule : bcts_file_model

//--- test/tb.sv
// Purpose: Bench for the bit executor
// Assumes: Four clocks per instruction cycle
// Notes:   Self-checking
`timescale 1ns/100ps
module tb;
    logic ref_clk = 0;
    logic reset = 1;
    bcts_pkg::bcts_insn_t     insn = '0;
    bcts_pkg::bcts_file_req_t req;
    logic [7:0] rdata;
    logic done, skip;
    bcts_pkg::bcts_phase_t phase;
    localparam logic [6:0] SENT = 7'h10;
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    bcts_exec bcts_exec_i (.ref_clk(ref_clk), .reset(reset), .insn(insn), .file_rdata(rdata),
        .file_req(req), .insn_done(done), .skip_active(skip), .phase(phase));
    bcts_file_model bcts_file_model_i (.ref_clk(ref_clk), .req(req), .rdata(rdata));
    initial forever #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 400) begin miscompares++; report_and_stop(); end
    end
    task automatic chk(string what, logic [7:0] e, logic [7:0] g);
        n_compared++;
        if (g !== e) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", what, e, g); end
    endtask : chk
    task automatic run(logic [3:0] o, logic [2:0] b, logic [6:0] a, logic [7:0] v, logic [7:0] e,
        logic es);
        int n_skip;
        int n_done;
        n_skip = 0;
        n_done = 0;
        bcts_file_model_i.mem[a] = v;
        bcts_file_model_i.mem[SENT] = 8'hFF;
        @(negedge ref_clk);
        while (phase != bcts_pkg::BCTS_Q4) @(negedge ref_clk);
        @(posedge ref_clk) insn <= '{1'b1, {o, b, a}};
        repeat (4)
        begin
            @(negedge ref_clk);
            n_skip += (skip === 1'b1);
            n_done += (done === 1'b1);
        end
        @(posedge ref_clk) insn <= '{1'b1, {bcts_pkg::OPC_BIT_CLEAR, 3'h0, SENT}};
        repeat (4)
        begin
            @(negedge ref_clk);
            n_skip += (skip === 1'b1);
            n_done += (done === 1'b1);
        end
        @(posedge ref_clk) insn <= '0;
        repeat (8)
        begin
            @(negedge ref_clk);
            n_skip += (skip === 1'b1);
            n_done += (done === 1'b1);
        end
        chk("file value", e, bcts_file_model_i.mem[a]);
        chk("next insn", es ? 8'hFF : 8'hFE, bcts_file_model_i.mem[SENT]);
        chk("skip clocks", es ? 8'h04 : 8'h00, 8'(n_skip));
        chk("done count", es ? 8'h01 : 8'h02, 8'(n_done));
    endtask : run
    task automatic report_and_stop();
        $display("miscompares=%0d n_compared=%0d", miscompares, n_compared);
        if (miscompares == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (5) @(posedge ref_clk);
        reset <= 0;
        run(4'h4, 3'h7, 7'h7F, 8'hC7, 8'h47, 0);
        run(4'h6, 3'h1, 7'h00, 8'h02, 8'h02, 0);
        run(4'h6, 3'h0, 7'h41, 8'hFE, 8'hFE, 1);
        report_and_stop();
    end
endmodule : tb

//--- verilog/bcts_exec.sv
// Purpose: Decode and execute the bit clear and bit test skip-if-clear instructions
// Assumes: Fetch presents one instruction word per instruction cycle, held through it;
//          the file returns read data by the Q3 phase of the cycle that asked
// Notes:   Other opcodes are ignored; the file itself lives outside
// Overview of operation
// - Bit clear zeroes chosen bit only
// - Test bit one: next instruction runs
// - Test bit zero: next instruction becomes no-op
// - One cycle, two on skip, all no-op
// - Seven-bit address, three-bit index decoded
`timescale 1ns/100ps
module bcts_exec
(
    input  wire logic                      ref_clk,
    input  wire logic                      reset,
    input  bcts_pkg::bcts_insn_t           insn,
    input  wire logic [7:0]                file_rdata,
    output bcts_pkg::bcts_file_req_t       file_req,
    output logic                           insn_done,
    output logic                           skip_active,
    output bcts_pkg::bcts_phase_t          phase
);

    localparam int unsigned OPC_W = bcts_pkg::OPC_HI - bcts_pkg::OPC_LO + 1;
    localparam int unsigned BW    = bcts_pkg::BIT_W;

    // Operation held for the current instruction cycle
    typedef enum logic [1:0]
    {
        BCTS_OP_NONE  = 2'h0,
        BCTS_OP_CLEAR = 2'h1,
        BCTS_OP_TEST  = 2'h3
    } bcts_op_t;

    bcts_pkg::bcts_phase_t              phase_w;
    logic                               qtr_en;

    logic [OPC_W-1:0]                   dec_opc;
    logic [bcts_pkg::BIT_W-1:0]         dec_bit;
    logic [bcts_pkg::ADDR_W-1:0]        dec_addr;
    bcts_op_t                           dec_op;

    bcts_op_t                           op_q;
    bcts_op_t                           op_d;
    logic [bcts_pkg::ADDR_W-1:0]        addr_q;
    logic [bcts_pkg::ADDR_W-1:0]        addr_d;
    logic [bcts_pkg::BIT_W-1:0]         bit_q;
    logic [bcts_pkg::BIT_W-1:0]         bit_d;
    logic                               skip_pend_q;
    logic                               skip_pend_d;
    logic                               skip_cyc_q;
    logic                               skip_cyc_d;
    bcts_pkg::bcts_file_req_t           req_q;
    bcts_pkg::bcts_file_req_t           req_d;

    logic [bcts_pkg::DATA_W-1:0]        cleared;
    logic                               tested_bit;

    // Quarter phase sequencer
    bcts_quarter_div bcts_quarter_div_i
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .phase   (phase_w),
        .qtr_en  (qtr_en)
    );

    default clocking cb_main @(posedge ref_clk);
    endclocking

    default disable iff (reset);

    // Field split of the instruction word
    always_comb
    begin
        dec_opc  = insn.word[bcts_pkg::OPC_HI:bcts_pkg::OPC_LO];
        dec_bit  = insn.word[bcts_pkg::BIT_HI:bcts_pkg::BIT_LO];
        dec_addr = insn.word[bcts_pkg::ADDR_HI:bcts_pkg::ADDR_LO];
        dec_op   = BCTS_OP_NONE;
        if (insn.valid)
        begin
            case (dec_opc)
                bcts_pkg::OPC_BIT_CLEAR: dec_op = BCTS_OP_CLEAR;
                bcts_pkg::OPC_BIT_TEST:  dec_op = BCTS_OP_TEST;
                default:                 dec_op = BCTS_OP_NONE;
            endcase
        end
    end

    // Modify stage: every bit kept except the chosen one
    for (genvar gi = 0; gi < bcts_pkg::DATA_W; gi++)
    begin : g_bit
        assign cleared[gi] = file_rdata[gi] & (bit_q != BW'(gi));
    end

    assign tested_bit = file_rdata[bit_q];

    // Phase sequencing of decode, read, modify and write
    always_comb
    begin
        op_d        = op_q;
        addr_d      = addr_q;
        bit_d       = bit_q;
        skip_pend_d = skip_pend_q;
        skip_cyc_d  = skip_cyc_q;
        req_d       = req_q;
        if (qtr_en)
        begin
            case (phase_w)
                bcts_pkg::BCTS_Q1:
                begin
                    req_d = '0;
                    if (skip_cyc_q)
                    begin
                        op_d = BCTS_OP_NONE;
                    end
                    else
                    begin
                        op_d   = dec_op;
                        addr_d = dec_addr;
                        bit_d  = dec_bit;
                        if (dec_op != BCTS_OP_NONE)
                        begin
                            req_d.rd_en = 1'b1;
                            req_d.addr  = dec_addr;
                        end
                    end
                end
                bcts_pkg::BCTS_Q2:
                begin
                    req_d = '0;
                end
                bcts_pkg::BCTS_Q3:
                begin
                    if (op_q == BCTS_OP_CLEAR)
                    begin
                        req_d.wr_en = 1'b1;
                        req_d.addr  = addr_q;
                        req_d.wdata = cleared;
                    end
                    if (op_q == BCTS_OP_TEST)
                    begin
                        skip_pend_d = ~tested_bit;
                    end
                end
                bcts_pkg::BCTS_Q4:
                begin
                    req_d       = '0;
                    skip_cyc_d  = skip_pend_q;
                    skip_pend_d = 1'b0;
                end
                default:
                begin
                    req_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            op_q        <= BCTS_OP_NONE;
            addr_q      <= '0;
            bit_q       <= '0;
            skip_pend_q <= 1'b0;
            skip_cyc_q  <= 1'b0;
            req_q       <= '0;
        end
        else
        begin
            op_q        <= op_d;
            addr_q      <= addr_d;
            bit_q       <= bit_d;
            skip_pend_q <= skip_pend_d;
            skip_cyc_q  <= skip_cyc_d;
            req_q       <= req_d;
        end
    end

    // Outputs; the whole skipped cycle is a no-operation
    assign file_req    = req_q;
    assign skip_active = skip_cyc_q;
    assign phase       = phase_w;
    assign insn_done   = qtr_en && (phase_w == bcts_pkg::BCTS_Q4) && (op_q != BCTS_OP_NONE);

    // Bit clear taken at decode
    sequence s_clear_taken;
        qtr_en && (phase_w == bcts_pkg::BCTS_Q1) && !skip_cyc_q && (dec_op == BCTS_OP_CLEAR);
    endsequence

    // Read, idle, write, idle over the following quarters
    sequence s_clear_rmw;
        file_req.rd_en ##1 !file_req.rd_en ##1 file_req.wr_en ##1 !file_req.wr_en;
    endsequence

    // Test instruction at its process quarter
    sequence s_test_zero;
        qtr_en && (phase_w == bcts_pkg::BCTS_Q3) && (op_q == BCTS_OP_TEST) && !tested_bit;
    endsequence

    sequence s_test_one;
        qtr_en && (phase_w == bcts_pkg::BCTS_Q3) && (op_q == BCTS_OP_TEST) && tested_bit;
    endsequence

    a_clear_rmw_order: assert property (s_clear_taken |=> s_clear_rmw)
        else $error("bit clear read-modify-write order broken");

    a_clear_addr_field: assert property (s_clear_taken |=> (file_req.addr == $past(dec_addr)))
        else $error("bit clear address field not used");

    a_clear_bit_zero: assert property (file_req.wr_en |-> (file_req.wdata[bit_q] == 1'b0))
        else $error("bit clear left the chosen bit set");

    a_clear_others_kept: assert property
        (file_req.wr_en |-> ($countones(file_req.wdata ^ $past(file_rdata)) <= 1))
        else $error("bit clear changed other bits");

    a_skip_on_zero: assert property (s_test_zero |-> ##2 skip_active)
        else $error("tested bit zero but no skip");

    a_no_skip_one: assert property (s_test_one |-> ##2 !skip_active)
        else $error("tested bit one but skip taken");

    a_skip_one_cycle: assert property
        ($rose(skip_active) |-> skip_active [*4] ##1 !skip_active)
        else $error("skip cycle length wrong");

    a_skip_no_access: assert property
        (skip_active |-> (!file_req.rd_en && !file_req.wr_en && !insn_done))
        else $error("skipped cycle did work");

endmodule : bcts_exec

//--- verilog/bcts_pkg.sv
// Purpose: Shared constants and types for the bit clear / bit test skip executor
// Assumes: 14-bit instruction word, 8-bit file registers, four quarter phases per cycle
// Notes:   Phases advance on a one-cycle enable from the quarter divider
package bcts_pkg;

    localparam int unsigned CLK_PERIOD_NS  = 40;
    localparam int unsigned QUARTER_NS     = 40;
    localparam int unsigned QUARTER_CYCLES =
        ((QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    localparam int unsigned INSN_W  = 14;
    localparam int unsigned ADDR_W  = 7;
    localparam int unsigned BIT_W   = 3;
    localparam int unsigned DATA_W  = 8;

    localparam int unsigned OPC_HI  = 13;
    localparam int unsigned OPC_LO  = 10;
    localparam int unsigned BIT_HI  = 9;
    localparam int unsigned BIT_LO  = 7;
    localparam int unsigned ADDR_HI = 6;
    localparam int unsigned ADDR_LO = 0;

    localparam logic [3:0] OPC_BIT_CLEAR = 4'h4;
    localparam logic [3:0] OPC_BIT_TEST  = 4'h6;

    typedef enum logic [1:0]
    {
        BCTS_Q1 = 2'b00,
        BCTS_Q2 = 2'b01,
        BCTS_Q3 = 2'b11,
        BCTS_Q4 = 2'b10
    } bcts_phase_t;

    typedef struct packed
    {
        logic              valid;
        logic [INSN_W-1:0] word;
    } bcts_insn_t;

    typedef struct packed
    {
        logic              rd_en;
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bcts_file_req_t;

endpackage : bcts_pkg

//--- verilog/bcts_quarter_div.sv
// Purpose: Quarter phase enable divider and phase sequencer
// Assumes: One clock; QUARTER_CYCLES clocks per quarter phase
// Notes:   qtr_en pulses one clock at the end of each quarter
`timescale 1ns/100ps
module bcts_quarter_div
(
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    output bcts_pkg::bcts_phase_t      phase,
    output logic                       qtr_en
);

    localparam int unsigned CW = 8;

    logic [CW-1:0]          cnt_q;
    logic [CW-1:0]          cnt_d;
    bcts_pkg::bcts_phase_t  phase_q;
    bcts_pkg::bcts_phase_t  phase_d;
    logic                   tick;

    always_comb
    begin
        tick    = (cnt_q == CW'(bcts_pkg::QUARTER_CYCLES - 1));
        cnt_d   = tick ? '0 : cnt_q + CW'(1);
        phase_d = phase_q;
        if (tick)
        begin
            case (phase_q)
                bcts_pkg::BCTS_Q1: phase_d = bcts_pkg::BCTS_Q2;
                bcts_pkg::BCTS_Q2: phase_d = bcts_pkg::BCTS_Q3;
                bcts_pkg::BCTS_Q3: phase_d = bcts_pkg::BCTS_Q4;
                bcts_pkg::BCTS_Q4: phase_d = bcts_pkg::BCTS_Q1;
                default:           phase_d = bcts_pkg::BCTS_Q1;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            cnt_q   <= '0;
            phase_q <= bcts_pkg::BCTS_Q1;
        end
        else
        begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign phase  = phase_q;
    assign qtr_en = tick;

endmodule : bcts_quarter_div
